/* File: rtl/dic_glitch_filter.sv */
// one input channel: two-flop synchroniser and pulse-width filter
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
`include "dic_params.svh"

module dic_glitch_filter
  import dic_pkg::*;
#(
  parameter int unsigned SLOW_CYCLES = `DIC_CYC_SLOW
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // pin and setting
  input  wire logic          rawIn,
  input  wire dic_filt_sel_t filtSel,
  // filtered level
  output logic               level
);

  localparam int CYC_NONE = `DIC_CYC_NONE;
  localparam int CYC_FAST = `DIC_CYC_FAST;
  localparam int CYC_STD  = `DIC_CYC_STD;

  dic_filt_st_t q;
  dic_filt_st_t d;
  logic [14:0]  thr;
  logic [15:0]  runLen;

  always_comb begin
    d = q;
    d.s1 = rawIn;
    d.s2 = q.s1;
    unique case (filtSel)
      DIC_FILT_NONE: thr = 15'(CYC_NONE);
      DIC_FILT_FAST: thr = 15'(CYC_FAST);
      DIC_FILT_STD:  thr = 15'(CYC_STD);
      DIC_FILT_SLOW: thr = 15'(SLOW_CYCLES);
    endcase
    if (q.s2 == q.lvl) begin
      d.cnt = 15'h0000;
    end else if (q.cnt + 15'h0001 >= thr) begin
      d.lvl = q.s2;
      d.cnt = 15'h0000;
    end else begin
      d.cnt = q.cnt + 15'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;

  // independent run length of a differing input, for the checks only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      runLen <= 16'h0000;
    end else if (q.s2 == q.lvl || d.lvl != q.lvl) begin
      runLen <= 16'h0000;
    end else if (runLen != 16'hFFFF) begin
      runLen <= runLen + 16'h0001;
    end
  end

  sequence sFlip;
    q.lvl != $past(q.lvl);
  endsequence

  chk_none_pass: assert property (@(posedge sys_clk) disable iff (!nrst)
    (filtSel == DIC_FILT_NONE && q.s2 != q.lvl) |=> (q.lvl == $past(q.s2)))
    else $error("unfiltered channel did not follow its input");

  chk_fast_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sFlip and $past(filtSel) == DIC_FILT_FAST) |-> $past(runLen) == 16'(CYC_FAST - 1))
    else $error("fast filter changed after the wrong width");

  chk_std_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sFlip and $past(filtSel) == DIC_FILT_STD) |-> $past(runLen) == 16'(CYC_STD - 1))
    else $error("standard filter changed after the wrong width");

  chk_slow_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sFlip and $past(filtSel) == DIC_FILT_SLOW) |-> $past(runLen) == 16'(SLOW_CYCLES - 1))
    else $error("slow filter changed after the wrong width");

endmodule // dic_glitch_filter

/* File: rtl/dic_params.svh */
// constants of the digital input conditioning block
// assumes a 10 MHz sys_clk; offsets are byte addresses on a 12-bit APB window
`ifndef DIC_PARAMS_SVH
`define DIC_PARAMS_SVH

// clock and filter thresholds, times in ns
`define DIC_CLK_PERIOD_NS 100
`define DIC_T_NONE_NS     40
`define DIC_T_FAST_NS     10240
`define DIC_T_STD_NS      163000
`define DIC_T_SLOW_NS     2620000
// least times round up, never below one cycle
`define DIC_CYC_NONE (((`DIC_T_NONE_NS + `DIC_CLK_PERIOD_NS - 1) / `DIC_CLK_PERIOD_NS) < 1 ? 1 : \
  ((`DIC_T_NONE_NS + `DIC_CLK_PERIOD_NS - 1) / `DIC_CLK_PERIOD_NS))
`define DIC_CYC_FAST ((`DIC_T_FAST_NS + `DIC_CLK_PERIOD_NS - 1) / `DIC_CLK_PERIOD_NS)
`define DIC_CYC_STD  ((`DIC_T_STD_NS + `DIC_CLK_PERIOD_NS - 1) / `DIC_CLK_PERIOD_NS)
`define DIC_CYC_SLOW ((`DIC_T_SLOW_NS + `DIC_CLK_PERIOD_NS - 1) / `DIC_CLK_PERIOD_NS)

// register offsets
`define DIC_OFF_FILT_LO  12'h000
`define DIC_OFF_FILT_HI  12'h004
`define DIC_OFF_LVL_LO   12'h008
`define DIC_OFF_LVL_HI   12'h00C
`define DIC_OFF_MP_LVL   12'h010
`define DIC_OFF_MP_CTRL  12'h014
`define DIC_OFF_INV_LO   12'h018
`define DIC_CH_BASE_HI   5'h02
`define DIC_CH_MODE      2'h0
`define DIC_CH_ARG_LO    2'h1
`define DIC_CH_ARG_HI    2'h2

// field positions in MP_CTRL
`define DIC_MPC_INV_LSB  0
`define DIC_MPC_DIR_LSB  4
`define DIC_MPC_EMU_LSB  8

// reset values
// channels 1 and 2 fast, channels 3 to 7 standard
`define DIC_RST_FILT_LO  14'h2AA5
`define DIC_RST_FILT_HI  24'hAAAA_AA
`define DIC_RST_EMU      4'h0

// input functions with their own argument range
`define DIC_FN_MAX       5'h18
`define DIC_FN_TASK      5'h02
`define DIC_FN_CMDBUF    5'h09
`define DIC_FN_OPMODE    5'h16
`define DIC_FN_SIGN      5'h17
`define DIC_MAX_TASK     64'h0000_0000_0000_0080
`define DIC_MAX_CMDBUF   64'h0000_0000_0000_0004
`define DIC_MAX_OPMODE   64'h0000_0000_0000_0020
`define DIC_MAX_SIGN     64'h0000_0000_0000_0808
`define DIC_EMU_PINREAD  4'hA

`endif

/* File: rtl/dic_pkg.sv */
// types of the digital input conditioning block
// the constants themselves live in dic_params.svh
package dic_pkg;

  typedef enum logic [1:0] {
    DIC_FILT_NONE,
    DIC_FILT_FAST,
    DIC_FILT_STD,
    DIC_FILT_SLOW
  } dic_filt_sel_t;

  typedef logic [4:0]         dic_func_t;
  typedef logic signed [63:0] dic_arg_t;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [14:0] cnt;
    logic        lvl;
  } dic_filt_st_t;

  typedef struct packed {
    logic                ack;
    logic                err;
    logic [31:0]         rdata;
    logic [13:0]         fLo;
    logic [23:0]         fHi;
    logic [6:0]          invLo;
    logic [2:0]          mpInv;
    logic [2:0]          mpDir;
    logic [3:0]          emu;
    logic [2:0]          mpS1;
    logic [2:0]          mpS2;
    logic [2:0]          mpLvl;
    logic [31:0]         argStage;
    logic [6:0][4:0]     mode;
    logic [6:0][63:0]    arg;
  } dic_top_st_t;

endpackage

/* File: rtl/dic_top.sv */
// digital input conditioning: filters, level readback, function argument regs
// assumes an APB3 master on sys_clk; pins are asynchronous and synchronised here
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "dic_params.svh"

// Notes on behaviour
// - filter select 0 passes every pulse, no filtering
// - filter select 1 needs pulses of about 10.24 us
// - filter select 2 needs pulses of about 163 us
// - filter select 3 needs pulses of about 2.62 ms
// - channels 21 to 32 filter select is 0 to 3, resets to 2
// - reading filter select returns it and leaves it unchanged
// - function 2 limits argument to 0..128, argument is task number
// - argument limited 0..4 for 9, 0..32 for 22, 0..2056 for 23
// - other functions take full signed range; argument resets to 0
// - function change leaving argument out of range zeroes the argument
// - channels 1..7 and 21..32 have a one-bit read-only level
// - multipurpose pins 9..11 report level after polarity invert
// - pin level only valid with emulation select 10 and direction input
// - invert 0 is active high, 1 is active low
module dic_top
  import dic_pkg::*;
#(
  parameter int unsigned SLOW_CYCLES = `DIC_CYC_SLOW
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // input pins
  input  wire logic [6:0]  dinLow,
  input  wire logic [11:0] dinHigh,
  input  wire logic [2:0]  mpPin,
  // conditioned levels and settings to the function logic
  output logic      [6:0]  levelLow,
  output logic      [11:0] levelHigh,
  output logic      [2:0]  mpDirection,
  output logic      [34:0] funcSelAll
);

  dic_top_st_t q;
  dic_top_st_t d;
  logic        access;
  logic        wrDone;
  logic        chHit;
  logic [2:0]  chIdx;
  logic [1:0]  chReg;
  logic        mpValid;
  logic [31:0] rdMux;
  logic        rdErr;
  dic_arg_t    newArg;

  // argument range for a given input function
  function automatic logic argOk(input logic [4:0] fn, input logic [63:0] a);
    logic [63:0] lim;
    logic        limited;
    lim     = 64'h0000_0000_0000_0000;
    limited = 1'b1;
    unique case (fn)
      `DIC_FN_TASK:   lim = `DIC_MAX_TASK;
      `DIC_FN_CMDBUF: lim = `DIC_MAX_CMDBUF;
      `DIC_FN_OPMODE: lim = `DIC_MAX_OPMODE;
      `DIC_FN_SIGN:   lim = `DIC_MAX_SIGN;
      default:        limited = 1'b0;
    endcase
    // limited ranges start at zero, so a negative value is out
    argOk = !limited || (!a[63] && a <= lim);
  endfunction

  // filters, one per channel
  genvar gi;
  generate
    for (gi = 0; gi < 19; gi++) begin : g_chan
      logic          lv;
      logic          raw;
      dic_filt_sel_t sel;
      // pin picked per bank, so no index ever falls outside its vector
      if (gi < 7) begin : g_lo
        assign sel = dic_filt_sel_t'(q.fLo[2*gi +: 2]);
        assign raw = dinLow[gi];
        assign levelLow[gi] = lv;
      end else begin : g_hi
        assign sel = dic_filt_sel_t'(q.fHi[2*(gi-7) +: 2]);
        assign raw = dinHigh[gi-7];
        assign levelHigh[gi-7] = lv;
      end
      dic_glitch_filter #(
        .SLOW_CYCLES (SLOW_CYCLES)
      ) u_filt (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .rawIn   (raw),
        .filtSel (sel),
        .level   (lv)
      );
    end
  endgenerate

  assign access  = psel && penable;
  assign wrDone  = access && q.ack && pwrite;
  assign chHit   = paddr[11:7] == `DIC_CH_BASE_HI && paddr[6:4] != 3'h7 && paddr[3:2] != 2'h3;
  assign chIdx   = paddr[6:4];
  assign chReg   = paddr[3:2];
  assign newArg  = {pwdata, q.argStage};
  // pin level tracked only in pin-read emulation with input direction
  assign mpValid = q.emu == `DIC_EMU_PINREAD;

  // read mux and decode
  always_comb begin
    rdMux = 32'h0000_0000;
    rdErr = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rdErr = 1'b1;
    end else if (chHit) begin
      unique case (chReg)
        `DIC_CH_MODE:   rdMux = {27'h000_0000, q.mode[chIdx]};
        `DIC_CH_ARG_LO: rdMux = q.arg[chIdx][31:0];
        default:        rdMux = q.arg[chIdx][63:32];
      endcase
    end else begin
      unique case (paddr)
        // plain read of the filter settings
        `DIC_OFF_FILT_LO: rdMux = {18'h0_0000, q.fLo};
        `DIC_OFF_FILT_HI: rdMux = {8'h00, q.fHi};
        // one-bit levels, channel 1 in bit 0
        `DIC_OFF_LVL_LO:  rdMux = {25'h000_0000, levelLow ^ q.invLo};
        `DIC_OFF_LVL_HI:  rdMux = {20'h0_0000, levelHigh};
        `DIC_OFF_MP_LVL:  rdMux = {29'h0000_0000, q.mpLvl};
        `DIC_OFF_MP_CTRL: rdMux = {20'h0_0000, q.emu, 1'b0, q.mpDir, 1'b0, q.mpInv};
        `DIC_OFF_INV_LO:  rdMux = {25'h000_0000, q.invLo};
        default:          rdErr = 1'b1;
      endcase
    end
  end

  always_comb begin
    d = q;
    // pins pass two flops before any use
    d.mpS1 = mpPin;
    d.mpS2 = q.mpS1;
    for (int b = 0; b < 3; b++) begin
      // level after polarity, invert 1 flips it
      if (mpValid && !q.mpDir[b]) begin
        d.mpLvl[b] = q.mpS2[b] ^ q.mpInv[b];
      end
    end
    // apb: one wait cycle, data registered in it
    if (access && !q.ack) begin
      d.ack   = 1'b1;
      d.err   = rdErr;
      d.rdata = pwrite ? 32'h0000_0000 : rdMux;
    end else begin
      d.ack = 1'b0;
    end
    if (wrDone && !q.err) begin
      if (chHit) begin
        unique case (chReg)
          `DIC_CH_MODE: begin
            if (pwdata[31:0] <= {27'h000_0000, `DIC_FN_MAX}) begin
              d.mode[chIdx] = pwdata[4:0];
              // stored argument out of the new range is zeroed
              if (!argOk(pwdata[4:0], q.arg[chIdx])) begin
                d.arg[chIdx] = 64'h0000_0000_0000_0000;
              end
            end
          end
          `DIC_CH_ARG_LO: d.argStage = pwdata;
          default: begin
            // task, other limits, wide default range
            if (argOk(q.mode[chIdx], newArg)) begin
              d.arg[chIdx] = newArg;
            end
          end
        endcase
      end else begin
        unique case (paddr)
          `DIC_OFF_FILT_LO: d.fLo = pwdata[13:0];
          // any 0..3 value per field accepted
          `DIC_OFF_FILT_HI: d.fHi = pwdata[23:0];
          `DIC_OFF_MP_CTRL: begin
            d.mpInv = pwdata[`DIC_MPC_INV_LSB +: 3];
            d.mpDir = pwdata[`DIC_MPC_DIR_LSB +: 3];
            d.emu   = pwdata[`DIC_MPC_EMU_LSB +: 4];
          end
          `DIC_OFF_INV_LO:  d.invLo = pwdata[6:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q       <= '0;
      // filter settings come out of reset at their defaults
      q.fLo   <= `DIC_RST_FILT_LO;
      q.fHi   <= `DIC_RST_FILT_HI;
      q.emu   <= `DIC_RST_EMU;
    end else begin
      q <= d;
    end
  end

  assign pready      = access && q.ack;
  assign pslverr     = access && q.ack && q.err;
  assign prdata      = q.rdata;
  assign mpDirection = q.mpDir;
  assign funcSelAll  = q.mode;

  // checks
  sequence sModeWr(int c);
    wrDone && !q.err && chHit && chIdx == 3'(c) && chReg == `DIC_CH_MODE
      && pwdata <= 32'h0000_0018;
  endsequence

  chk_filt_rst: assert property (@(posedge sys_clk)
    $rose(nrst) |-> q.fHi == `DIC_RST_FILT_HI && q.fLo == `DIC_RST_FILT_LO)
    else $error("filter settings not at reset defaults");

  chk_read_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
    (access && !pwrite && paddr[11:3] == 9'h000) |=> $stable(q.fLo) && $stable(q.fHi))
    else $error("reading a filter setting changed it");

  chk_arg_range: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrDone |=> argOk(q.mode[0], q.arg[0]) && argOk(q.mode[6], q.arg[6]))
    else $error("argument outside the range of its function");

  chk_arg_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sModeWr(0) ##0 !argOk(pwdata[4:0], q.arg[0])) |=> q.arg[0] == 64'h0000_0000_0000_0000)
    else $error("argument not zeroed on function change");

  chk_mp_level: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mpValid && !q.mpDir[0]) |=> q.mpLvl[0] == $past(q.mpS2[0] ^ q.mpInv[0]))
    else $error("pin level does not follow pin and polarity");

  chk_mp_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!mpValid && !$past(mpValid)) |=> $stable(q.mpLvl))
    else $error("pin level moved outside pin-read emulation");

endmodule // dic_top

/* File: test/dic_pin_model.sv */
// partner model: switches and sensors on the input pins
// assumes pins change just after rising sys_clk edges
`timescale 1ns/1ps

module dic_pin_model (
  // clock
  input  wire logic        sys_clk,
  // pins towards the block
  output logic      [6:0]  dinLow,
  output logic      [11:0] dinHigh,
  output logic      [2:0]  mpPin
);
  initial begin
    dinLow  = 7'h00;
    dinHigh = 12'h000;
    mpPin   = 3'h0;
  end

  // static switch levels; channel 21 is left to pulse
  task automatic setPins(input logic [6:0] lo, input logic [10:0] hi, input logic [2:0] mp);
    @(posedge sys_clk);
    dinLow        <= lo;
    dinHigh[11:1] <= hi;
    mpPin         <= mp;
  endtask

  // one high pulse of w cycles on channel 21
  task automatic pulse(input int w);
    @(posedge sys_clk);
    dinHigh[0] <= 1'b1;
    repeat (w) @(posedge sys_clk);
    dinHigh[0] <= 1'b0;
  endtask
endmodule // dic_pin_model

/* File: test/dic_top_tb.sv */
// self-checking bench for dic_top with a register model
// assumes one wait state apb slave; slow filter shortened to 40 cycles
`timescale 1ns/1ps
`include "dic_params.svh"

module dic_top_tb;
  import dic_pkg::*;
  localparam int SLOW = 40;
  logic        sys_clk = 1'b0;
  logic        nrst;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [6:0]  dinLow, levelLow;
  logic [11:0] dinHigh, levelHigh;
  logic [2:0]  mpPin, mpDirection;
  logic [34:0] funcSelAll;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          mMode[7];
  longint      mArg[7];

  always #50 sys_clk = ~sys_clk;

  dic_top #(.SLOW_CYCLES(SLOW)) dic_top_inst (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dinLow(dinLow), .dinHigh(dinHigh), .mpPin(mpPin), .levelLow(levelLow),
    .levelHigh(levelHigh), .mpDirection(mpDirection), .funcSelAll(funcSelAll));
  dic_pin_model dic_pin_model_inst (
    .sys_clk(sys_clk), .dinLow(dinLow), .dinHigh(dinHigh), .mpPin(mpPin));

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // pready ends this wait; the hang guard ends it if pready never comes
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    check(64'(e), 64'h0, "write error");
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    check(64'(e), 64'h0, "read error");
  endtask

  function automatic longint lim(input int m);
    case (m)
      2: return 128;
      9: return 4;
      22: return 32;
      23: return 2056;
      default: return -1;
    endcase
  endfunction

  function automatic bit inRange(input int m, input longint v);
    return lim(m) < 0 || (v >= 0 && v <= lim(m));
  endfunction

  task automatic cmpCh(input int k);
    logic [31:0] lo, hi, md;
    rd(12'h100 + 12'(k * 16), md);
    rd(12'h104 + 12'(k * 16), lo);
    rd(12'h108 + 12'(k * 16), hi);
    check(64'(md), 64'(mMode[k]), "mode");
    check({hi, lo}, mArg[k], "argument");
    check(64'(funcSelAll[k*5+:5]), 64'(mMode[k]), "mode out");
  endtask

  task automatic writeMode(input int k, input int m);
    wr(12'h100 + 12'(k * 16), 32'(m));
    if (m <= 24) begin
      mMode[k] = m;
      if (!inRange(m, mArg[k])) mArg[k] = 0;
    end
    cmpCh(k);
  endtask

  task automatic writeArg(input int k, input longint v);
    wr(12'h104 + 12'(k * 16), v[31:0]);
    wr(12'h108 + 12'(k * 16), v[63:32]);
    if (inRange(mMode[k], v)) mArg[k] = v;
    cmpCh(k);
  endtask

  task automatic pulseTest(input int w, input bit pass);
    bit seen;
    seen = 0;
    fork
      dic_pin_model_inst.pulse(w);
      repeat (w + 8) @(posedge sys_clk) if (levelHigh[0] === 1'b1) seen = 1;
    join
    repeat (w + 8) @(posedge sys_clk);
    check(64'(seen), 64'(pass), "pulse seen");
  endtask

  initial begin
    int n, k, fns[5];
    logic [6:0] lo, inv;
    logic [10:0] hi;
    logic [2:0] mp, mi;
    logic e;
    fns = '{2, 9, 22, 23, 0};
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    void'($urandom(81));
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`DIC_OFF_FILT_LO, rdv);
    check(rdv, 64'h0000_2AA5, "filt lo reset");
    repeat (2) begin
      rd(`DIC_OFF_FILT_HI, rdv);
      check(rdv, 64'h00AA_AAAA, "filt hi reset");
    end
    rd(`DIC_OFF_MP_LVL, rdv);
    check(rdv, 64'h0, "pin level reset");
    apb(1'b0, 12'h01C, 32'h0, rdv, e);
    check(64'(e), 64'h1, "unmapped");
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      n = (s == 0) ? 1 : (s == 1) ? (10240 + 99) / 100 : (s == 2) ? (163000 + 99) / 100 : SLOW;
      wr(`DIC_OFF_FILT_HI, 32'h00AA_AAA8 | 32'(s));
      rd(`DIC_OFF_FILT_HI, rdv);
      check(rdv, 64'h00AA_AAA8 | 64'(s), "filt select");
      if (n > 1) pulseTest(n * 15 / 16 - 1, 1'b0);
      pulseTest(n * 17 / 16 + 2, 1'b1);
    end
    $display("test filter done");
    wr(`DIC_OFF_FILT_LO, 32'h0);
    wr(`DIC_OFF_FILT_HI, 32'h0);
    inv = 7'($urandom);
    mi = 3'($urandom);
    lo = 7'($urandom);
    hi = 11'($urandom);
    mp = 3'($urandom);
    wr(`DIC_OFF_INV_LO, 32'(inv));
    wr(`DIC_OFF_MP_CTRL, 32'h0000_0A00 | 32'(mi));
    dic_pin_model_inst.setPins(lo, hi, mp);
    repeat (8) @(posedge sys_clk);
    check(64'(levelLow), 64'(lo), "low levels");
    check(64'(levelHigh[11:1]), 64'(hi), "high levels");
    rd(`DIC_OFF_LVL_LO, rdv);
    check(rdv, 64'(lo ^ inv), "low readback");
    rd(`DIC_OFF_LVL_HI, rdv);
    check(rdv, 64'({hi, 1'b0}), "high readback");
    rd(`DIC_OFF_MP_LVL, rdv);
    check(rdv, 64'(mp ^ mi), "pin level");
    check(64'(mpDirection), 64'h0, "direction");
    wr(`DIC_OFF_MP_CTRL, 32'h0000_0A70 | 32'(mi));
    dic_pin_model_inst.setPins(lo, hi, ~mp);
    repeat (8) @(posedge sys_clk);
    rd(`DIC_OFF_MP_LVL, rdv);
    check(rdv, 64'(mp ^ mi), "pin level held");
    check(64'(mpDirection), 64'h7, "direction");
    $display("test levels done");
    for (int c = 0; c < 7; c++) begin
      mMode[c] = 0;
      mArg[c] = 0;
    end
    foreach (fns[i]) begin
      k = $urandom % 7;
      writeMode(k, 0);
      writeArg(k, 200);
      writeMode(k, fns[i]);
      writeArg(k, lim(fns[i]));
      writeArg(k, lim(fns[i]) + 1);
      writeArg(k, -1);
      writeArg(k, {$urandom, $urandom});
      writeMode(k, 25);
    end
    $display("test argument done");
    results();
  end
endmodule // dic_top_tb
